// [hw/iopl_sync.sv]
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes each bit is independent; no word coherence is promised.
`timescale 1ns/1ps
module iopl_sync #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         pclk,
   input  wire logic         presetn,
   // Data
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_r;
   logic [W-1:0] sync_nxt;

   always_comb begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;

endmodule

// [hw/iopl_top.sv]
// Port latch, direction and pin control for three ports: a general port with
// alternate functions, an analog-capable port and a four-pin clock port.
// Assumes an APB master on pclk and board pins asynchronous to pclk.
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module iopl_top (
   // Clock and reset
   input  wire logic                           pclk,
   input  wire logic                           presetn,
   // APB slave
   input  wire logic [iopl_pkg::ADDR_W-1:0]    paddr,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [iopl_pkg::DATA_W-1:0]    pwdata,
   output logic      [iopl_pkg::DATA_W-1:0]    prdata,
   output logic                                pready,
   output logic                                pslverr,
   // General port pins and alternate functions
   input  wire logic [iopl_pkg::GP_W-1:0]      gp_pin_in,
   output logic      [iopl_pkg::GP_W-1:0]      gp_pin_out,
   output logic      [iopl_pkg::GP_W-1:0]      gp_pin_oe_n,
   output logic      [iopl_pkg::GP_W-1:0]      gp_pullup_en,
   input  wire logic [iopl_pkg::GP_W-1:0]      gp_alt_out,
   input  wire logic [iopl_pkg::GP_W-1:0]      gp_alt_en,
   output logic      [iopl_pkg::GP_W-1:0]      gp_alt_in,
   // Analog-capable port pins
   input  wire logic [iopl_pkg::AN_W-1:0]      an_pin_in,
   output logic      [iopl_pkg::AN_W-1:0]      an_pin_out,
   output logic      [iopl_pkg::AN_W-1:0]      an_pin_oe_n,
   output logic      [iopl_pkg::AN_W-1:0]      analog_inputs_en,
   // Clock-capable port pins
   input  wire logic [iopl_pkg::CK_W-1:0]      ck_pin_in,
   output logic      [iopl_pkg::CK_W-1:0]      ck_pin_out,
   output logic      [iopl_pkg::CK_W-1:0]      ck_pin_oe_n,
   output logic      [iopl_pkg::CK_W-1:0]      ck_pullup_en,
   output logic                                external_main_clock_input,
   output logic                                external_sub_clock_input,
   output logic                                resonator_main_en,
   output logic                                resonator_sub_en
);

   // Synchronised pin levels.
   logic [iopl_pkg::GP_W-1:0]   gp_in_s;
   logic [iopl_pkg::AN_W-1:0]   an_in_s;
   logic [iopl_pkg::CK_W-1:0]   ck_in_s;

   // Software-visible state.
   logic [iopl_pkg::GP_W-1:0]   gp_latch_r,  gp_latch_nxt;
   logic [iopl_pkg::GP_W-1:0]   gp_dir_r,    gp_dir_nxt;
   logic [iopl_pkg::GP_W-1:0]   gp_pull_r,   gp_pull_nxt;
   logic [iopl_pkg::AN_W-1:0]   an_latch_r,  an_latch_nxt;
   logic [iopl_pkg::AN_W-1:0]   an_dir_r,    an_dir_nxt;
   logic [iopl_pkg::ACFG_W-1:0] acfg_r,      acfg_nxt;
   logic [iopl_pkg::CHAN_W-1:0] chan_r,      chan_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_latch_r,  ck_latch_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_dir_r,    ck_dir_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_pull_r,   ck_pull_nxt;
   logic [iopl_pkg::PORT_W-1:0] ckmode_r,    ckmode_nxt;
   logic                        pready_r,    pready_nxt;
   logic                        pslverr_r,   pslverr_nxt;
   logic [iopl_pkg::DATA_W-1:0] prdata_r,    prdata_nxt;

   // Derived views.
   logic [iopl_pkg::AN_W-1:0]   an_dig;
   logic [iopl_pkg::CK_W-1:0]   ck_special;
   logic [iopl_pkg::PORT_W-1:0] gp_view;
   logic [iopl_pkg::PORT_W-1:0] an_view;
   logic [iopl_pkg::PORT_W-1:0] ck_view;
   logic [iopl_pkg::PORT_W-1:0] status;

   // Registered pin-side outputs.
   logic [iopl_pkg::GP_W-1:0]   gp_out_r,    gp_out_nxt;
   logic [iopl_pkg::GP_W-1:0]   gp_oe_n_r,   gp_oe_n_nxt;
   logic [iopl_pkg::GP_W-1:0]   gp_pu_r,     gp_pu_nxt;
   logic [iopl_pkg::GP_W-1:0]   gp_alt_in_r, gp_alt_in_nxt;
   logic [iopl_pkg::AN_W-1:0]   an_out_r,    an_out_nxt;
   logic [iopl_pkg::AN_W-1:0]   an_oe_n_r,   an_oe_n_nxt;
   logic [iopl_pkg::AN_W-1:0]   an_feed_r,   an_feed_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_out_r,    ck_out_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_oe_n_r,   ck_oe_n_nxt;
   logic [iopl_pkg::CK_W-1:0]   ck_pu_r,     ck_pu_nxt;
   logic                        ext_main_r,  ext_main_nxt;
   logic                        ext_sub_r,   ext_sub_nxt;
   logic                        res_main_r,  res_main_nxt;
   logic                        res_sub_r,   res_sub_nxt;

   // Input-mode bits return the pin, output-mode bits return the latch.
   function automatic logic [iopl_pkg::PORT_W-1:0] port_read(
      input logic [iopl_pkg::PORT_W-1:0] latch,
      input logic [iopl_pkg::PORT_W-1:0] dir,
      input logic [iopl_pkg::PORT_W-1:0] pin
   );
      port_read = (dir & pin) | (~dir & latch);
   endfunction

   function automatic logic [iopl_pkg::PORT_W-1:0] bit_op(
      input logic [iopl_pkg::PORT_W-1:0]    v,
      input logic [iopl_pkg::RMW_OP_W-1:0]  op,
      input logic [iopl_pkg::RMW_BIT_W-1:0] b
   );
      logic [iopl_pkg::PORT_W-1:0] m;
      m = iopl_pkg::PORT_W'(1) << b;
      case (iopl_pkg::iopl_op_t'(op))
         iopl_pkg::IOPL_OP_SET: bit_op = v | m;
         iopl_pkg::IOPL_OP_CLR: bit_op = v & ~m;
         iopl_pkg::IOPL_OP_TGL: bit_op = v ^ m;
         default:               bit_op = v;
      endcase
   endfunction

   iopl_sync #(.W(iopl_pkg::GP_W)) u_gp_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (gp_pin_in),
      .sync_out (gp_in_s)
   );

   iopl_sync #(.W(iopl_pkg::AN_W)) u_an_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (an_pin_in),
      .sync_out (an_in_s)
   );

   iopl_sync #(.W(iopl_pkg::CK_W)) u_ck_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (ck_pin_in),
      .sync_out (ck_in_s)
   );

   // Pin configuration views shared by reads, bit operations and pin drive.
   always_comb begin
      for (int i = 0; i < iopl_pkg::AN_W; i++) begin
         // Codes above the last legal one count as all-digital, which keeps analog off.
         an_dig[i] = (iopl_pkg::ACFG_W'(i) < acfg_r) || (acfg_r >= iopl_pkg::ACFG_MAX);
      end
      ck_special = '0;
      ck_special[iopl_pkg::CK_MAIN_A] = ckmode_r[iopl_pkg::CKM_OSC_MAIN]
                                        & ~ckmode_r[iopl_pkg::CKM_EXT_MAIN];
      ck_special[iopl_pkg::CK_MAIN_B] = ckmode_r[iopl_pkg::CKM_OSC_MAIN];
      ck_special[iopl_pkg::CK_SUB_A]  = ckmode_r[iopl_pkg::CKM_OSC_SUB]
                                        & ~ckmode_r[iopl_pkg::CKM_EXT_SUB];
      ck_special[iopl_pkg::CK_SUB_B]  = ckmode_r[iopl_pkg::CKM_OSC_SUB];
      gp_view = port_read(gp_latch_r, gp_dir_r, gp_in_s);
      // Analog-selected pins have no digital input buffer; in input mode they read as 0.
      an_view = port_read(an_latch_r, an_dir_r, an_in_s & an_dig);
      ck_view = port_read(iopl_pkg::PORT_W'(ck_latch_r), iopl_pkg::PORT_W'(ck_dir_r),
                          iopl_pkg::PORT_W'(ck_in_s & ~ck_special));
      status = '0;
      status[iopl_pkg::ST_AN_OUT_CONFLICT] = |(~an_dig & ~an_dir_r);
      status[iopl_pkg::ST_CHAN_DIGITAL]    = an_dig[chan_r];
      status[iopl_pkg::ST_ACFG_BAD]        = acfg_r > iopl_pkg::ACFG_MAX;
   end

   // APB slave and register file.
   always_comb begin
      logic                                setup;
      logic                                wr;
      logic [iopl_pkg::RMW_PORT_W-1:0]     rport;
      logic [iopl_pkg::RMW_OP_W-1:0]       rop;
      logic [iopl_pkg::RMW_BIT_W-1:0]      rbit;
      setup = psel & ~penable;
      wr    = psel & penable & pready_r & pwrite;
      rport = pwdata[iopl_pkg::RMW_PORT_LSB +: iopl_pkg::RMW_PORT_W];
      rop   = pwdata[iopl_pkg::RMW_OP_LSB +: iopl_pkg::RMW_OP_W];
      rbit  = pwdata[iopl_pkg::RMW_BIT_LSB +: iopl_pkg::RMW_BIT_W];
      gp_latch_nxt = gp_latch_r;
      gp_dir_nxt   = gp_dir_r;
      gp_pull_nxt  = gp_pull_r;
      an_latch_nxt = an_latch_r;
      an_dir_nxt   = an_dir_r;
      acfg_nxt     = acfg_r;
      chan_nxt     = chan_r;
      ck_latch_nxt = ck_latch_r;
      ck_dir_nxt   = ck_dir_r;
      ck_pull_nxt  = ck_pull_r;
      ckmode_nxt   = ckmode_r;
      pready_nxt   = setup;
      pslverr_nxt  = 1'b0;
      prdata_nxt   = '0;
      if (setup) begin
         if (paddr == iopl_pkg::OFF_GP_DATA) begin
            prdata_nxt = iopl_pkg::DATA_W'(gp_view);
         end else if (paddr == iopl_pkg::OFF_GP_DIR) begin
            prdata_nxt = iopl_pkg::DATA_W'(gp_dir_r);
         end else if (paddr == iopl_pkg::OFF_GP_PULL) begin
            prdata_nxt = iopl_pkg::DATA_W'(gp_pull_r);
         end else if (paddr == iopl_pkg::OFF_AN_DATA) begin
            prdata_nxt = iopl_pkg::DATA_W'(an_view);
         end else if (paddr == iopl_pkg::OFF_AN_DIR) begin
            prdata_nxt = iopl_pkg::DATA_W'(an_dir_r);
         end else if (paddr == iopl_pkg::OFF_AN_CFG) begin
            prdata_nxt = iopl_pkg::DATA_W'(acfg_r);
         end else if (paddr == iopl_pkg::OFF_AN_CHAN) begin
            prdata_nxt = iopl_pkg::DATA_W'(chan_r);
         end else if (paddr == iopl_pkg::OFF_CK_DATA) begin
            prdata_nxt = iopl_pkg::DATA_W'(ck_view);
         end else if (paddr == iopl_pkg::OFF_CK_DIR) begin
            prdata_nxt = iopl_pkg::DATA_W'(ck_dir_r);
         end else if (paddr == iopl_pkg::OFF_CK_PULL) begin
            prdata_nxt = iopl_pkg::DATA_W'(ck_pull_r);
         end else if (paddr == iopl_pkg::OFF_CK_MODE) begin
            prdata_nxt = iopl_pkg::DATA_W'(ckmode_r);
         end else if (paddr == iopl_pkg::OFF_RMW) begin
            prdata_nxt = '0;
         end else if (paddr == iopl_pkg::OFF_STATUS) begin
            prdata_nxt = iopl_pkg::DATA_W'(status);
         end else begin
            pslverr_nxt = 1'b1;
         end
      end
      if (wr) begin
         if (paddr == iopl_pkg::OFF_GP_DATA) begin
            gp_latch_nxt = pwdata[iopl_pkg::GP_W-1:0];
         end else if (paddr == iopl_pkg::OFF_GP_DIR) begin
            gp_dir_nxt = pwdata[iopl_pkg::GP_W-1:0];
         end else if (paddr == iopl_pkg::OFF_GP_PULL) begin
            gp_pull_nxt = pwdata[iopl_pkg::GP_W-1:0];
         end else if (paddr == iopl_pkg::OFF_AN_DATA) begin
            an_latch_nxt = pwdata[iopl_pkg::AN_W-1:0];
         end else if (paddr == iopl_pkg::OFF_AN_DIR) begin
            an_dir_nxt = pwdata[iopl_pkg::AN_W-1:0];
         end else if (paddr == iopl_pkg::OFF_AN_CFG) begin
            acfg_nxt = pwdata[iopl_pkg::ACFG_W-1:0];
         end else if (paddr == iopl_pkg::OFF_AN_CHAN) begin
            chan_nxt = pwdata[iopl_pkg::CHAN_W-1:0];
         end else if (paddr == iopl_pkg::OFF_CK_DATA) begin
            ck_latch_nxt = pwdata[iopl_pkg::CK_W-1:0];
         end else if (paddr == iopl_pkg::OFF_CK_DIR) begin
            ck_dir_nxt = pwdata[iopl_pkg::CK_W-1:0];
         end else if (paddr == iopl_pkg::OFF_CK_PULL) begin
            ck_pull_nxt = pwdata[iopl_pkg::CK_W-1:0];
         end else if (paddr == iopl_pkg::OFF_CK_MODE) begin
            ckmode_nxt = pwdata[iopl_pkg::PORT_W-1:0];
         end else if (paddr == iopl_pkg::OFF_RMW) begin
            // The whole port is read and rewritten, so input-mode latch bits
            // pick up the level the port reads back (0 for analog- or clock-selected pins), not their old latch value.
            if (rport == iopl_pkg::PORT_GP) begin
               gp_latch_nxt = bit_op(gp_view, rop, rbit);
            end else if (rport == iopl_pkg::PORT_AN) begin
               an_latch_nxt = bit_op(an_view, rop, rbit);
            end else if (rport == iopl_pkg::PORT_CK) begin
               ck_latch_nxt = iopl_pkg::CK_W'(bit_op(ck_view, rop, rbit));
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_latch_r <= iopl_pkg::LATCH_RST;
         gp_dir_r   <= iopl_pkg::DIR_RST;
         gp_pull_r  <= iopl_pkg::PULL_RST;
         an_latch_r <= iopl_pkg::LATCH_RST;
         an_dir_r   <= iopl_pkg::DIR_RST;
         acfg_r     <= iopl_pkg::ACFG_RST;
         chan_r     <= iopl_pkg::CHAN_RST;
         ck_latch_r <= iopl_pkg::CK_W'(iopl_pkg::LATCH_RST);
         ck_dir_r   <= iopl_pkg::CK_W'(iopl_pkg::DIR_RST);
         ck_pull_r  <= iopl_pkg::CK_W'(iopl_pkg::PULL_RST);
         ckmode_r   <= iopl_pkg::CKMODE_RST;
         pready_r   <= 1'b0;
         pslverr_r  <= 1'b0;
         prdata_r   <= '0;
      end else begin
         gp_latch_r <= gp_latch_nxt;
         gp_dir_r   <= gp_dir_nxt;
         gp_pull_r  <= gp_pull_nxt;
         an_latch_r <= an_latch_nxt;
         an_dir_r   <= an_dir_nxt;
         acfg_r     <= acfg_nxt;
         chan_r     <= chan_nxt;
         ck_latch_r <= ck_latch_nxt;
         ck_dir_r   <= ck_dir_nxt;
         ck_pull_r  <= ck_pull_nxt;
         ckmode_r   <= ckmode_nxt;
         pready_r   <= pready_nxt;
         pslverr_r  <= pslverr_nxt;
         prdata_r   <= prdata_nxt;
      end
   end

   // Pin drive. An active alternate output replaces the latch; the latch
   // values software must preset for alternate use then only matter while
   // the peripheral is idle and gp_alt_en is low.
   always_comb begin
      gp_out_nxt    = (gp_alt_en & gp_alt_out) | (~gp_alt_en & gp_latch_r);
      gp_oe_n_nxt   = gp_dir_r;
      gp_pu_nxt     = gp_pull_r & gp_dir_r & ~gp_alt_en;
      gp_alt_in_nxt = gp_in_s;
      an_out_nxt    = an_latch_r;
      // An analog-selected pin is never driven, even when its direction says output.
      an_oe_n_nxt   = an_dir_r | ~an_dig;
      for (int i = 0; i < iopl_pkg::AN_W; i++) begin
         an_feed_nxt[i] = ~an_dig[i] & an_dir_r[i] & (chan_r == iopl_pkg::CHAN_W'(i));
      end
      ck_out_nxt    = ck_latch_r;
      ck_oe_n_nxt   = ck_dir_r | ck_special;
      ck_pu_nxt     = ck_pull_r & ck_dir_r & ~ck_special;
      ext_main_nxt  = ckmode_r[iopl_pkg::CKM_OSC_MAIN] & ckmode_r[iopl_pkg::CKM_EXT_MAIN];
      ext_sub_nxt   = ckmode_r[iopl_pkg::CKM_OSC_SUB] & ckmode_r[iopl_pkg::CKM_EXT_SUB];
      res_main_nxt  = ckmode_r[iopl_pkg::CKM_OSC_MAIN] & ~ckmode_r[iopl_pkg::CKM_EXT_MAIN];
      res_sub_nxt   = ckmode_r[iopl_pkg::CKM_OSC_SUB] & ~ckmode_r[iopl_pkg::CKM_EXT_SUB];
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gp_out_r    <= '0;
         gp_oe_n_r   <= '1;
         gp_pu_r     <= '0;
         gp_alt_in_r <= '0;
         an_out_r    <= '0;
         an_oe_n_r   <= '1;
         an_feed_r   <= '0;
         ck_out_r    <= '0;
         ck_oe_n_r   <= '1;
         ck_pu_r     <= '0;
         ext_main_r  <= 1'b0;
         ext_sub_r   <= 1'b0;
         res_main_r  <= 1'b0;
         res_sub_r   <= 1'b0;
      end else begin
         gp_out_r    <= gp_out_nxt;
         gp_oe_n_r   <= gp_oe_n_nxt;
         gp_pu_r     <= gp_pu_nxt;
         gp_alt_in_r <= gp_alt_in_nxt;
         an_out_r    <= an_out_nxt;
         an_oe_n_r   <= an_oe_n_nxt;
         an_feed_r   <= an_feed_nxt;
         ck_out_r    <= ck_out_nxt;
         ck_oe_n_r   <= ck_oe_n_nxt;
         ck_pu_r     <= ck_pu_nxt;
         ext_main_r  <= ext_main_nxt;
         ext_sub_r   <= ext_sub_nxt;
         res_main_r  <= res_main_nxt;
         res_sub_r   <= res_sub_nxt;
      end
   end

   assign prdata                    = prdata_r;
   assign pready                    = pready_r;
   assign pslverr                   = pslverr_r;
   assign gp_pin_out                = gp_out_r;
   assign gp_pin_oe_n               = gp_oe_n_r;
   assign gp_pullup_en              = gp_pu_r;
   assign gp_alt_in                 = gp_alt_in_r;
   assign an_pin_out                = an_out_r;
   assign an_pin_oe_n               = an_oe_n_r;
   assign analog_inputs_en          = an_feed_r;
   assign ck_pin_out                = ck_out_r;
   assign ck_pin_oe_n               = ck_oe_n_r;
   assign ck_pullup_en              = ck_pu_r;
   assign external_main_clock_input = ext_main_r;
   assign external_sub_clock_input  = ext_sub_r;
   assign resonator_main_en         = res_main_r;
   assign resonator_sub_en          = res_sub_r;

endmodule

// [shared/iopl_pkg.sv]
// Package for the I/O port latch block: register offsets, field layouts,
// reset values and operation codes.
// Assumes a 32-bit APB with byte addresses, each register one aligned word.
package iopl_pkg;

   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int PORT_W = 8;
   localparam int GP_W   = 8;
   localparam int AN_W   = 8;
   localparam int CK_W   = 4;
   localparam int CHAN_W = 3;
   localparam int ACFG_W = 4;

   // Register byte offsets.
   localparam logic [ADDR_W-1:0] OFF_GP_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_GP_DIR  = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_GP_PULL = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_AN_DATA = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_AN_DIR  = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_AN_CFG  = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_AN_CHAN = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_CK_DATA = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_CK_DIR  = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_CK_PULL = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_CK_MODE = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_RMW     = 8'h2C;
   localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h30;

   // Reset values; direction 1 means input.
   localparam logic [PORT_W-1:0] LATCH_RST  = 8'h00;
   localparam logic [PORT_W-1:0] DIR_RST    = 8'hFF;
   localparam logic [PORT_W-1:0] PULL_RST   = 8'h00;
   localparam logic [ACFG_W-1:0] ACFG_RST   = 4'h0;
   localparam logic [ACFG_W-1:0] ACFG_MAX   = 4'h8;
   localparam logic [CHAN_W-1:0] CHAN_RST   = 3'h0;
   localparam logic [PORT_W-1:0] CKMODE_RST = 8'h00;

   // Clock pin mode fields.
   localparam int CKM_EXT_MAIN = 7;
   localparam int CKM_OSC_MAIN = 6;
   localparam int CKM_EXT_SUB  = 5;
   localparam int CKM_OSC_SUB  = 4;

   // Oscillator-capable pin positions within the clock port.
   localparam int CK_MAIN_A = 0;
   localparam int CK_MAIN_B = 1;
   localparam int CK_SUB_A  = 2;
   localparam int CK_SUB_B  = 3;

   // Read-modify-write command fields.
   localparam int RMW_BIT_LSB  = 0;
   localparam int RMW_BIT_W    = 3;
   localparam int RMW_OP_LSB   = 4;
   localparam int RMW_OP_W     = 2;
   localparam int RMW_PORT_LSB = 8;
   localparam int RMW_PORT_W   = 2;

   localparam logic [RMW_PORT_W-1:0] PORT_GP = 2'h0;
   localparam logic [RMW_PORT_W-1:0] PORT_AN = 2'h1;
   localparam logic [RMW_PORT_W-1:0] PORT_CK = 2'h2;

   typedef enum logic [RMW_OP_W-1:0] {
      IOPL_OP_NOP = 2'h0,
      IOPL_OP_SET = 2'h1,
      IOPL_OP_CLR = 2'h2,
      IOPL_OP_TGL = 2'h3
   } iopl_op_t;

   // Status bit positions.
   localparam int ST_AN_OUT_CONFLICT = 0;
   localparam int ST_CHAN_DIGITAL    = 1;
   localparam int ST_ACFG_BAD        = 2;

endpackage

// [tb/iopl_board.sv]
// Board model for one port: each pin is the block's drive, else the pull-up, else the board.
// Assumes the board holds every pin that nobody else drives at the level given on ext.
`timescale 1ns/1ps
module iopl_board #(
   parameter int W = 8
) (
   // Block side
   input  wire logic [W-1:0] drv,
   input  wire logic [W-1:0] oe_n,
   input  wire logic [W-1:0] pu,
   // Board side
   input  wire logic [W-1:0] ext,
   output logic      [W-1:0] lvl
);
   assign lvl = (~oe_n & drv) | (oe_n & (pu | ext));
endmodule

// [tb/iopl_monitor.sv]
// Checker for the port latch block, attached to iopl_top by the bind below.
// Assumes gp_alt_en stays low while the general port latch is being written.
`timescale 1ns/1ps
module iopl_monitor (
   // Clock, reset and bus
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   // Pins
   input wire logic [7:0]  gp_pin_out,
   input wire logic [7:0]  gp_pin_oe_n,
   input wire logic [7:0]  gp_pullup_en,
   input wire logic [7:0]  gp_alt_en,
   input wire logic [7:0]  an_pin_oe_n,
   input wire logic [7:0]  analog_inputs_en,
   input wire logic [3:0]  ck_pin_out,
   input wire logic [3:0]  ck_pin_oe_n,
   input wire logic [3:0]  ck_pullup_en,
   input wire logic        resonator_main_en
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pready && pwrite;
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_data;
      wr && paddr == 8'h00 |-> ##2 (gp_pin_out == $past(pwdata[7:0], 2));
   endproperty
   a_data: assert property (p_data) else $error("pin does not drive latch");
   property p_dir;
      wr && paddr == 8'h04 |-> ##2 (gp_pin_oe_n == $past(pwdata[7:0], 2));
   endproperty
   a_dir: assert property (p_dir) else $error("driver enable wrong");
   property p_pull;
      (gp_pullup_en & ~gp_pin_oe_n) == 8'h00 && (ck_pullup_en & ~ck_pin_oe_n) == 4'h0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull-up on driven pin");
   property p_altpu; (gp_pullup_en & $past(gp_alt_en)) == 8'h00; endproperty
   a_altpu: assert property (p_altpu) else $error("pull-up on alternate pin");
   property p_an;
      $onehot0(analog_inputs_en) && (analog_inputs_en & ~an_pin_oe_n) == 8'h00;
   endproperty
   a_an: assert property (p_an) else $error("converter feed wrong");
   property p_rst; $rose(presetn) |-> gp_pin_out == 8'h00 && ck_pin_out == 4'h0; endproperty
   a_rst: assert property (p_rst) else $error("latch not cleared");
   property p_osc; resonator_main_en |-> ck_pin_oe_n[1] && !ck_pullup_en[1]; endproperty
   a_osc: assert property (p_osc) else $error("oscillator pin driven");
   property p_ckm;
      wr && paddr == 8'h28 && pwdata[7:4] == 4'h0 |-> ##2 !resonator_main_en;
   endproperty
   a_ckm: assert property (p_ckm) else $error("clock pin not a port pin");
endmodule
bind iopl_top iopl_monitor mon (.*);

// [tb/iopl_top_tb.sv]
// Bench for the port latch block: APB master, board models and scenarios.
// Assumes the checker is attached by its own bind.
`timescale 1ns/1ps
module iopl_top_tb;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err_r, res_main;
   logic [7:0]  gp_out, gp_oe_n, gp_pu, gp_lvl, an_out, an_oe_n, an_lvl, an_en;
   logic [7:0]  gp_ext = 8'h3C;
   logic [7:0]  an_ext = 8'h5A;
   logic [7:0]  alt_out = 8'h00;
   logic [7:0]  alt_en = 8'h00;
   logic [3:0]  ck_out, ck_oe_n, ck_pu, ck_lvl;
   logic [3:0]  ck_ext = 4'h9;
   int          n_errors = 0;
   int          n_checks = 0;
   iopl_top uut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .gp_pin_in(gp_lvl), .gp_pin_out(gp_out), .gp_pin_oe_n(gp_oe_n), .gp_pullup_en(gp_pu),
      .gp_alt_out(alt_out), .gp_alt_en(alt_en), .gp_alt_in(),
      .an_pin_in(an_lvl), .an_pin_out(an_out), .an_pin_oe_n(an_oe_n), .analog_inputs_en(an_en),
      .ck_pin_in(ck_lvl), .ck_pin_out(ck_out), .ck_pin_oe_n(ck_oe_n), .ck_pullup_en(ck_pu),
      .external_main_clock_input(), .external_sub_clock_input(),
      .resonator_main_en(res_main), .resonator_sub_en());
   iopl_board #(.W(8)) brd_gp (.drv(gp_out), .oe_n(gp_oe_n), .pu(gp_pu),
      .ext(gp_ext), .lvl(gp_lvl));
   iopl_board #(.W(8)) brd_an (.drv(an_out), .oe_n(an_oe_n), .pu(8'h00),
      .ext(an_ext), .lvl(an_lvl));
   iopl_board #(.W(4)) brd_ck (.drv(ck_out), .oe_n(ck_oe_n), .pu(ck_pu),
      .ext(ck_ext), .lvl(ck_lvl));
   always #50 pclk = ~pclk;
   task automatic complete_run();
      $display("Checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // The request holds until pready is seen high; a bounded wait lets a dead slave end the run.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      for (k = 0; k < 16; k++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      {err_r, rd} = {pslverr, prdata};
      {psel, penable} <= 2'b00;
      if (k == 16) begin
         n_errors++;
         complete_run();
      end
   endtask
   task automatic t_latch();
      chk({gp_oe_n, gp_out, ck_oe_n, ck_out}, 32'hFF00F0);
      apb(1'b1, 8'h04, 32'h0F);
      apb(1'b1, 8'h00, 32'hA5);
      repeat (2) @(posedge pclk);
      chk({gp_oe_n, gp_out}, 32'h0FA5);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'hAC);
      apb(1'b1, 8'h2C, 32'h31);
      apb(1'b1, 8'h04, 32'h00);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'hAE);
      apb(1'b0, 8'h3C, 32'h0);
      chk({rd[30:0], err_r}, 32'h1);
   endtask
   task automatic t_pull_alt();
      apb(1'b1, 8'h04, 32'h0F);
      apb(1'b1, 8'h08, 32'hFF);
      alt_en <= 8'h11;
      alt_out <= 8'h11;
      repeat (2) @(posedge pclk);
      chk({gp_pu, gp_out}, 32'h0EBF);
      alt_en <= 8'h00;
   endtask
   task automatic t_an_ck();
      apb(1'b1, 8'h14, 32'h4);
      apb(1'b1, 8'h18, 32'h5);
      repeat (2) @(posedge pclk);
      chk(an_en, 32'h20);
      apb(1'b1, 8'h18, 32'h2);
      apb(1'b1, 8'h10, 32'h00);
      apb(1'b1, 8'h0C, 32'hFF);
      repeat (2) @(posedge pclk);
      chk({an_en, an_oe_n, 4'h0, an_out[3:0]}, 32'hF00F);
      // Both prohibited settings above must show in the status word.
      apb(1'b0, 8'h30, 32'h0);
      chk(rd, 32'h3);
      apb(1'b1, 8'h20, 32'h0);
      apb(1'b1, 8'h1C, 32'hF);
      repeat (2) @(posedge pclk);
      chk({ck_oe_n, ck_out}, 32'h0F);
      apb(1'b1, 8'h28, 32'h40);
      repeat (2) @(posedge pclk);
      chk({res_main, ck_oe_n[1:0]}, 32'h7);
      apb(1'b1, 8'h28, 32'h0);
      repeat (2) @(posedge pclk);
      chk({res_main, ck_oe_n}, 32'h0);
   endtask
   // A reset in mid-run, with latches holding ones, must clear them again.
   task automatic t_reset();
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk({gp_out, ck_oe_n, ck_out}, 32'h00F0);
      apb(1'b1, 8'h04, 32'h00);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h00);
   endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_latch();
      t_pull_alt();
      t_an_ck();
      t_reset();
      complete_run();
   end
endmodule
